// file: common/cpp_params.svh
// Constants of the charger power-path controller: offsets, fields, resets, timing.
// Assumes inclusion by its bare name; definitions only.
`ifndef CPP_PARAMS_SVH
`define CPP_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses, one word each)
`define CPP_ADDR_W        8
`define CPP_DATA_W        32
`define CPP_OFS_CTRL      8'h00
`define CPP_OFS_STATE     8'h04
`define CPP_OFS_FAULT     8'h08

// ==========================================================================
// Field positions
`define CPP_CTRL_HIZ_BIT  0
`define CPP_CTRL_INH_BIT  1
`define CPP_CTRL_BOFF_BIT 2
`define CPP_FLT_PG_BIT    1
`define CPP_FLT_FAULT_BIT 5

// ==========================================================================
// Reset values
`define CPP_CTRL_RST      3'h0
`define CPP_PG_RST        1'b0
`define CPP_FAULT_RST     1'b0
`define CPP_SENSE_RST     13'h0100

// ==========================================================================
// Timing: figures as printed, cycle counts derived from the clock rate
`define CPP_CLK_HZ        20000000
`define CPP_DGL_MS        30
`define CPP_ALERT_US      256
`define CPP_DGL_CYC       ((`CPP_DGL_MS * `CPP_CLK_HZ) / 1000)
`define CPP_ALERT_CYC     ((`CPP_ALERT_US * (`CPP_CLK_HZ / 1000)) / 1000)
`define CPP_DGL_CNT_W     20
`define CPP_ALERT_CNT_W   13

`endif

// file: common/cpp_pkg.sv
// Types of the charger power-path controller.
// Assumes cpp_params.svh for the constants; this package holds types only.
package cpp_pkg;

  // ========================================================================
  // Operating modes
  typedef enum logic [2:0] {
    CPP_START,
    CPP_BATTERY_DISCHARGE,
    CPP_CHARGING,
    CPP_SYSTEM_ONLY,
    CPP_STORAGE
  } cpp_mode_t;

  // ========================================================================
  // Analog comparator and detector levels
  typedef struct packed {
    logic porBat;         // Battery above power-on threshold
    logic porIn;          // Input above power-on threshold
    logic vinOverOvp;     // Input above over-voltage threshold
    logic vinBelowOvpExit;// Input below over-voltage exit level
    logic vinBelowUvlo;   // Input below lockout level
    logic vinAboveUvloHys;// Input above lockout plus hysteresis
    logic vinAboveBatIn;  // Input above battery plus entry margin
    logic vinAboveSysIn;  // Input above system plus entry margin
    logic vinBelowBatOut; // Input below battery plus exit margin
    logic vinBelowSysOut; // Input below system minus exit margin
    logic dieHot;         // Die above thermal regulation level
    logic inputLimited;   // Input current or voltage limit active
    logic sysBelowBat;    // System dropped below battery
  } cpp_sense_t;

  // ========================================================================
  // Power switch and loop controls
  typedef struct packed {
    logic inputBlockSwitchEn;
    logic inputLinearSwitchEn;
    logic batterySwitchEn;
    logic inputLoopEn;
    logic lowPowerEn;
    logic chargeReduce;
    logic supplementEn;
  } cpp_switch_t;

endpackage

// file: rtl/cpp_path_fsm.sv
// Mode state machine of a single-cell charger power path, with input fault
// deglitch, host alert pulse and read-clear status.
// Assumes analog comparator levels and a plain register port.
//
// How it works
// (RQ1) Discharge mode: only battery switch on.
// (RQ2) Charging mode: input and battery paths on.
// (RQ3) System-only: both input switches, battery off.
// (RQ4) Storage mode: all paths off, low power.
// (RQ5) Valid input, no highz, inhibited: system-only first.
// (RQ6) Inhibit cleared in system-only: go charging.
// (RQ7) Input removed: battery switch on, discharge mode.
// (RQ8) Host sets battery-off: storage, system unpowered.
// (RQ9) Die too hot: reduce charge current.
// (RQ10) Power-on detected: registers default, port ready.
// (RQ11) Over-voltage: input switch off at once.
// (RQ12) Over-voltage recovery waits full deglitch time.
// (RQ13) Undervoltage: input switch and loop off.
// (RQ14) Undervoltage recovery waits full deglitch time.
// (RQ15) Input fault: one fixed low alert pulse.
// (RQ16) Fault clears power-good, sets fault; read-clear.
// (RQ17) Input valid needs all entry conditions.
// (RQ18) Input valid drops on exit margins.
// (RQ19) Overload: cut charge, then battery supplements.
// (RQ20) Deglitch restarts on lapse; inputs synchronised.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cpp_params.svh"

module cpp_path_fsm #(
  parameter int unsigned DGL_CYC   = `CPP_DGL_CYC,
  parameter int unsigned ALERT_CYC = `CPP_ALERT_CYC
) (
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire cpp_pkg::cpp_sense_t      sense,
  input  wire logic [`CPP_ADDR_W-1:0]   regAddr,
  input  wire logic [`CPP_DATA_W-1:0]   regWdata,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic      [`CPP_DATA_W-1:0]   regRdata,
  output cpp_pkg::cpp_switch_t          switches,
  output cpp_pkg::cpp_mode_t            mode,
  output logic                          inputValid,
  output logic                          alertOut,
  output logic                          alertOe
);
  import cpp_pkg::*;

  // ========================================================================
  // Helpers
  // Deglitch step: count while qualified, zero on lapse
  function automatic logic [`CPP_DGL_CNT_W-1:0] dglNext(
    input logic [`CPP_DGL_CNT_W-1:0] cnt,
    input logic                      qual
  );
    logic [`CPP_DGL_CNT_W-1:0] lim;
    lim = DGL_CYC[`CPP_DGL_CNT_W-1:0];
    if (!qual) begin
      dglNext = '0;
    end else if (cnt >= lim) begin
      dglNext = lim;
    end else begin
      dglNext = cnt + 1'b1;
    end
  endfunction

  // ========================================================================
  // Input synchroniser
  cpp_sense_t senseMeta_q;
  cpp_sense_t senseSync_q;

  // (RQ20) two-stage sync of comparators
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      senseMeta_q <= `CPP_SENSE_RST;
      senseSync_q <= `CPP_SENSE_RST;
    end else begin
      senseMeta_q <= sense;
      senseSync_q <= senseMeta_q;
    end
  end

  // ========================================================================
  // Power-on detection
  logic porOk;
  // (RQ10) logic awake when either supply is up
  assign porOk = senseSync_q.porBat | senseSync_q.porIn;

  // ========================================================================
  // Over-voltage and undervoltage lockouts
  logic                      ovpLock_q;
  logic                      uvloLock_q;
  logic [`CPP_DGL_CNT_W-1:0] ovpCnt_q;
  logic [`CPP_DGL_CNT_W-1:0] ovpCnt_d;
  logic [`CPP_DGL_CNT_W-1:0] uvloCnt_q;
  logic [`CPP_DGL_CNT_W-1:0] uvloCnt_d;
  logic                      ovpDone;
  logic                      uvloDone;
  logic                      inputOk;

  // (RQ12) recovery qualified only below exit level
  assign ovpCnt_d  = dglNext(ovpCnt_q, ovpLock_q & senseSync_q.vinBelowOvpExit
                                       & ~senseSync_q.vinOverOvp);
  // (RQ14) recovery qualified only above hysteresis level
  assign uvloCnt_d = dglNext(uvloCnt_q, uvloLock_q & senseSync_q.vinAboveUvloHys
                                        & ~senseSync_q.vinBelowUvlo);
  assign ovpDone   = (ovpCnt_q == DGL_CYC[`CPP_DGL_CNT_W-1:0]);
  assign uvloDone  = (uvloCnt_q == DGL_CYC[`CPP_DGL_CNT_W-1:0]);
  assign inputOk   = ~ovpLock_q & ~uvloLock_q & ~senseSync_q.vinOverOvp
                     & ~senseSync_q.vinBelowUvlo;

  // Lock flags and deglitch counters
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovpLock_q  <= 1'b0;
      uvloLock_q <= 1'b1;
      ovpCnt_q   <= '0;
      uvloCnt_q  <= '0;
    end else if (!porOk) begin
      ovpLock_q  <= 1'b0;
      uvloLock_q <= 1'b1;
      ovpCnt_q   <= '0;
      uvloCnt_q  <= '0;
    end else begin
      // (RQ11) lock at once on over-voltage
      ovpLock_q  <= senseSync_q.vinOverOvp | (ovpLock_q & ~ovpDone);
      // (RQ13) lock at once on undervoltage
      uvloLock_q <= senseSync_q.vinBelowUvlo | (uvloLock_q & ~uvloDone);
      ovpCnt_q   <= senseSync_q.vinOverOvp ? '0 : ovpCnt_d;
      uvloCnt_q  <= senseSync_q.vinBelowUvlo ? '0 : uvloCnt_d;
    end
  end

  // ========================================================================
  // Input-valid qualifier with hysteresis
  logic inValid_q;
  logic inValidSet;
  logic inValidClr;

  // (RQ17) all entry conditions at once
  assign inValidSet = ~senseSync_q.vinBelowUvlo & ~senseSync_q.vinOverOvp
                      & senseSync_q.vinAboveBatIn & senseSync_q.vinAboveSysIn;
  // (RQ18) any exit margin crossed
  assign inValidClr = senseSync_q.vinBelowBatOut | senseSync_q.vinBelowSysOut
                      | senseSync_q.vinBelowUvlo | senseSync_q.vinOverOvp;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      inValid_q <= 1'b0;
    end else if (!porOk || inValidClr) begin
      inValid_q <= 1'b0;
    end else if (inValidSet) begin
      inValid_q <= 1'b1;
    end
  end
  assign inputValid = inValid_q;

  // ========================================================================
  // Fault events and host alert pulse
  logic                       ovpSeen_q;
  logic                       uvloSeen_q;
  logic                       faultEvent;
  logic [`CPP_ALERT_CNT_W-1:0] alertCnt_q;
  logic                       alertOn_q;

  // Rising edge of a synced fault level
  assign faultEvent = (senseSync_q.vinOverOvp & ~ovpSeen_q)
                      | (senseSync_q.vinBelowUvlo & ~uvloSeen_q);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovpSeen_q  <= 1'b0;
      uvloSeen_q <= 1'b1;
      alertCnt_q <= '0;
      alertOn_q  <= 1'b0;
    end else begin
      ovpSeen_q  <= senseSync_q.vinOverOvp;
      uvloSeen_q <= senseSync_q.vinBelowUvlo;
      // (RQ15) fixed-length low pulse, retriggered by a new event
      if (faultEvent && porOk) begin
        alertOn_q  <= 1'b1;
        alertCnt_q <= ALERT_CYC[`CPP_ALERT_CNT_W-1:0] - 1'b1;
      end else if (alertOn_q && alertCnt_q != '0) begin
        alertCnt_q <= alertCnt_q - 1'b1;
      end else begin
        alertOn_q  <= 1'b0;
      end
    end
  end
  // Open-drain: only ever pulls low
  assign alertOut = 1'b0;
  assign alertOe  = alertOn_q;

  // ========================================================================
  // Register decode
  logic [2:0] ctrl_q;
  logic       pgFlag_q;
  logic       faultFlag_q;
  logic       selCtrl;
  logic       selState;
  logic       selFault;
  logic       wrCtrl;
  logic       rdFault;
  logic       hizSel;
  logic       chargeInhibit;
  logic       batterySwitchOff;

  assign selCtrl  = (regAddr == `CPP_OFS_CTRL);
  assign selState = (regAddr == `CPP_OFS_STATE);
  assign selFault = (regAddr == `CPP_OFS_FAULT);
  assign wrCtrl   = regWrite & selCtrl;
  assign rdFault  = regRead & selFault;

  assign hizSel           = ctrl_q[`CPP_CTRL_HIZ_BIT];
  assign chargeInhibit    = ctrl_q[`CPP_CTRL_INH_BIT];
  assign batterySwitchOff = ctrl_q[`CPP_CTRL_BOFF_BIT];

  // Control register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `CPP_CTRL_RST;
    end else if (!porOk) begin
      // (RQ10) defaults while unpowered
      ctrl_q <= `CPP_CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_q <= regWdata[2:0];
    end
  end

  // Status flags: a new fault wins over the read clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pgFlag_q    <= `CPP_PG_RST;
      faultFlag_q <= `CPP_FAULT_RST;
    end else if (!porOk) begin
      pgFlag_q    <= `CPP_PG_RST;
      faultFlag_q <= `CPP_FAULT_RST;
    end else if (faultEvent) begin
      // (RQ16) power good cleared, fault set
      pgFlag_q    <= 1'b0;
      faultFlag_q <= 1'b1;
    end else if (rdFault) begin
      // (RQ16) read clears both
      pgFlag_q    <= 1'b0;
      faultFlag_q <= 1'b0;
    end else if (inputOk && inValid_q && !pgFlag_q && !faultFlag_q) begin
      pgFlag_q    <= 1'b1;
    end
  end

  // ========================================================================
  // Mode state machine
  cpp_mode_t mode_q;
  cpp_mode_t mode_d;
  logic      inputAvail;

  assign inputAvail = inputOk & inValid_q & ~hizSel;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      CPP_START: begin
        // (RQ5) first mode on valid input is system-only
        if (inputAvail) begin
          mode_d = CPP_SYSTEM_ONLY;
        end else begin
          mode_d = CPP_BATTERY_DISCHARGE;
        end
      end
      CPP_BATTERY_DISCHARGE: begin
        if (inputAvail) begin
          mode_d = CPP_SYSTEM_ONLY;
        end
      end
      CPP_SYSTEM_ONLY: begin
        // (RQ7) input lost, fall to discharge
        if (!inputAvail) begin
          mode_d = CPP_BATTERY_DISCHARGE;
        // (RQ6) inhibit cleared, start charging
        end else if (!chargeInhibit) begin
          mode_d = CPP_CHARGING;
        end
      end
      CPP_CHARGING: begin
        // (RQ7) input lost, fall to discharge
        if (!inputAvail) begin
          mode_d = CPP_BATTERY_DISCHARGE;
        end else if (chargeInhibit) begin
          mode_d = CPP_SYSTEM_ONLY;
        end
      end
      CPP_STORAGE: begin
        if (!batterySwitchOff) begin
          mode_d = CPP_START;
        end
      end
      default: mode_d = CPP_START;
    endcase
    // (RQ8) host battery-off overrides every mode
    if (batterySwitchOff) begin
      mode_d = CPP_STORAGE;
    end
  end

  // ========================================================================
  // Switch controls per next mode
  cpp_switch_t sw_d;
  cpp_switch_t sw_q;

  always_comb begin
    sw_d = '0;
    case (mode_d)
      CPP_BATTERY_DISCHARGE: begin
        // (RQ1) battery to system only
        sw_d.batterySwitchEn = 1'b1;
      end
      CPP_CHARGING: begin
        // (RQ2) input and battery paths together
        sw_d.inputBlockSwitchEn  = 1'b1;
        sw_d.inputLinearSwitchEn = 1'b1;
        sw_d.batterySwitchEn     = 1'b1;
        // (RQ9) thermal; (RQ19) load before charge
        sw_d.chargeReduce        = senseSync_q.dieHot | senseSync_q.inputLimited;
        // (RQ19) battery supplements a sagging system
        sw_d.supplementEn        = senseSync_q.inputLimited & senseSync_q.sysBelowBat;
      end
      CPP_SYSTEM_ONLY: begin
        // (RQ3) both input switches, battery off
        sw_d.inputBlockSwitchEn  = 1'b1;
        sw_d.inputLinearSwitchEn = 1'b1;
      end
      CPP_STORAGE: begin
        // (RQ4) everything off, low consumption
        sw_d.lowPowerEn = 1'b1;
      end
      default: sw_d = '0;
    endcase
    // (RQ13) loop controller off under lockout
    sw_d.inputLoopEn = inputOk & sw_d.inputLinearSwitchEn;
  end

  // State and switch registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= CPP_START;
      sw_q   <= '0;
    end else if (!porOk) begin
      mode_q <= CPP_START;
      sw_q   <= '0;
    end else begin
      mode_q <= mode_d;
      sw_q   <= sw_d;
    end
  end
  assign switches = sw_q;
  assign mode     = mode_q;

  // ========================================================================
  // Read data, one cycle after the read strobe
  logic [`CPP_DATA_W-1:0] rdMux;
  logic [`CPP_DATA_W-1:0] stateWord;
  logic [`CPP_DATA_W-1:0] faultWord;
  logic [`CPP_DATA_W-1:0] rdata_q;

  assign stateWord = {17'h0, ovpLock_q, uvloLock_q, inValid_q,
                      sw_q, mode_q, alertOn_q, senseSync_q.dieHot};
  assign faultWord = {26'h0, faultFlag_q, 3'b000, pgFlag_q, 1'b0};

  // Unmapped offsets read zero
  assign rdMux = selCtrl  ? {29'h0, ctrl_q} :
                 selState ? stateWord :
                 selFault ? faultWord : 32'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= regRead ? rdMux : '0;
    end
  end
  assign regRdata = rdata_q;

endmodule // cpp_path_fsm

// file: testbench/cpp_path_chk.sv
// Port checker of the charger power-path mode machine.
// Assumes cpp_pkg and cpp_params.svh; bound into every cpp_path_fsm.
`timescale 1ns/1ps
`include "cpp_params.svh"

module cpp_path_chk #(
  parameter int unsigned DGL_CYC   = `CPP_DGL_CYC,
  parameter int unsigned ALERT_CYC = `CPP_ALERT_CYC
) (
  input wire logic                   mclk,
  input wire logic                   arst_n,
  input wire cpp_pkg::cpp_sense_t    sense,
  input wire logic [`CPP_ADDR_W-1:0] regAddr,
  input wire logic [`CPP_DATA_W-1:0] regWdata,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [`CPP_DATA_W-1:0] regRdata,
  input wire cpp_pkg::cpp_switch_t   switches,
  input wire cpp_pkg::cpp_mode_t     mode,
  input wire logic                   inputValid,
  input wire logic                   alertOut,
  input wire logic                   alertOe
);
  import cpp_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // Helper counters
  int unsigned alertLen_q;
  int unsigned ovpOk_q;
  int unsigned uvOk_q;
  wire         ovpQual = sense.vinBelowOvpExit && !sense.vinOverOvp;
  wire         uvQual  = sense.vinAboveUvloHys && !sense.vinBelowUvlo;

  // Alert length and clean-input run lengths
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alertLen_q <= 0;
      ovpOk_q    <= 0;
      uvOk_q     <= 0;
    end else begin
      alertLen_q <= alertOe ? alertLen_q + 1 : 0;
      ovpOk_q    <= !ovpQual ? 0 : (ovpOk_q < DGL_CYC ? ovpOk_q + 1 : ovpOk_q);
      uvOk_q     <= !uvQual ? 0 : (uvOk_q < DGL_CYC ? uvOk_q + 1 : uvOk_q);
    end
  end

  // ==========================================================================
  // Assertions
  a_discharge_paths: assert property (
    mode == CPP_BATTERY_DISCHARGE |-> switches.batterySwitchEn
      && !switches.inputBlockSwitchEn && !switches.inputLinearSwitchEn)
    else $error("discharge switches");
  a_charge_paths: assert property (
    mode == CPP_CHARGING |-> switches.batterySwitchEn
      && switches.inputBlockSwitchEn && switches.inputLinearSwitchEn)
    else $error("charging switches");
  a_sysonly_paths: assert property (
    mode == CPP_SYSTEM_ONLY |-> !switches.batterySwitchEn
      && switches.inputBlockSwitchEn && switches.inputLinearSwitchEn)
    else $error("system-only switches");
  a_storage_paths: assert property (
    mode == CPP_STORAGE |-> switches.lowPowerEn && !switches.batterySwitchEn
      && !switches.inputBlockSwitchEn && !switches.inputLinearSwitchEn)
    else $error("storage path on");
  a_storage_entry: assert property (
    regWrite && regAddr == `CPP_OFS_CTRL && regWdata[`CPP_CTRL_BOFF_BIT]
      && (sense.porBat || sense.porIn) |-> ##[1:3] mode == CPP_STORAGE)
    else $error("storage not reached");
  a_ovp_cut: assert property (
    $rose(sense.vinOverOvp) |-> ##[1:4] !switches.inputBlockSwitchEn)
    else $error("input on after over-voltage");
  a_uvlo_cut: assert property (
    $rose(sense.vinBelowUvlo) |-> ##[1:4] !switches.inputBlockSwitchEn
      && !switches.inputLoopEn)
    else $error("input on after undervoltage");
  a_recover_wait: assert property (
    $rose(switches.inputBlockSwitchEn) |-> ovpOk_q >= DGL_CYC && uvOk_q >= DGL_CYC)
    else $error("early input recovery");
  a_alert_length: assert property (
    $fell(alertOe) |-> alertLen_q == ALERT_CYC && !alertOut)
    else $error("alert length");
  a_alert_cause: assert property (
    $rose(alertOe) |-> $past(sense.vinOverOvp, 2) || $past(sense.vinBelowUvlo, 2))
    else $error("alert without fault");
  a_valid_exit: assert property (
    (sense.vinBelowBatOut || sense.vinBelowSysOut) [*4] |-> !inputValid)
    else $error("input valid held");

  // Main scenarios reached
  c_charging: cover property (mode == CPP_CHARGING);
  c_storage: cover property (mode == CPP_STORAGE);
  c_alert: cover property ($rose(alertOe));

endmodule // cpp_path_chk

bind cpp_path_fsm cpp_path_chk #(.DGL_CYC(DGL_CYC), .ALERT_CYC(ALERT_CYC)) i_cpp_path_chk (
  .mclk(mclk), .arst_n(arst_n), .sense(sense), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .switches(switches), .mode(mode), .inputValid(inputValid), .alertOut(alertOut),
  .alertOe(alertOe));

// file: testbench/cpp_host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes registered read data, one cycle late.
`timescale 1ns/1ps
`include "cpp_params.svh"

module cpp_host_model (
  input  wire logic                   mclk,
  output logic     [`CPP_ADDR_W-1:0]  regAddr,
  output logic     [`CPP_DATA_W-1:0]  regWdata,
  output logic                        regWrite,
  output logic                        regRead,
  input  wire logic [`CPP_DATA_W-1:0] regRdata
);
  // Idle bus at time zero
  initial {regAddr, regWdata, regWrite, regRead} = '0;

  task automatic wr(input logic [`CPP_ADDR_W-1:0] a, input logic [`CPP_DATA_W-1:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [`CPP_ADDR_W-1:0] a, output logic [`CPP_DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask
endmodule // cpp_host_model

// file: testbench/testbench.sv
// Self-checking bench of the charger power-path mode machine.
// Assumes short deglitch and alert counts; drives the analog levels.
`timescale 1ns/1ps
`include "cpp_params.svh"

module testbench;
  import cpp_pkg::*;
  localparam int unsigned DGL  = 20;
  localparam int unsigned ALRT = 8;

  logic                   mclk = 1'b0;
  logic                   arst_n;
  cpp_sense_t             sense;
  logic [`CPP_ADDR_W-1:0] regAddr;
  logic [`CPP_DATA_W-1:0] regWdata;
  logic                   regWrite;
  logic                   regRead;
  logic [`CPP_DATA_W-1:0] regRdata;
  cpp_switch_t            switches;
  cpp_mode_t              mode;
  logic                   inputValid;
  logic                   alertOut;
  logic                   alertOe;
  logic [`CPP_DATA_W-1:0] rdat;
  int                     n_mismatch = 0;
  int                     compares = 0;
  int                     cyc = 0;
  int                     n;
  int                     alen;

  cpp_path_fsm #(.DGL_CYC(DGL), .ALERT_CYC(ALRT)) i_cpp_path_fsm (
    .mclk(mclk), .arst_n(arst_n), .sense(sense), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .switches(switches), .mode(mode), .inputValid(inputValid), .alertOut(alertOut),
    .alertOe(alertOe));
  cpp_host_model i_cpp_host_model (
    .mclk(mclk), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata));

  // ==========================================================================
  // Clock, timeout and report
  always #25 mclk = ~mclk;

  // Cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      $display("timeout after %0d cycles", cyc);
      close_out;
    end
  end

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_mode(input string what, input cpp_mode_t exp);
    compares++;
    if (mode !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, mode);
    end
  endtask

  task automatic wait_mode(input cpp_mode_t m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask

  // Length of the next alert pulse in cycles
  task automatic count_alert;
    alen = 0;
    n = 0;
    while (alertOe !== 1'b1 && n < 12) begin
      @(negedge mclk);
      n++;
    end
    while (alertOe === 1'b1 && alen < 60) begin
      @(negedge mclk);
      alen++;
    end
  endtask

  // Charging returns no sooner than deglitch
  task automatic recover(input string what);
    wait_mode(CPP_CHARGING, DGL + 30);
    chk_word(what, 1, n >= DGL && n < DGL + 30);
  endtask

  function automatic logic [31:0] paths();
    return {25'h0, switches & 7'h7C};
  endfunction

  task automatic end_test(input string name);
    $display("test %s done, mismatches %0d", name, n_mismatch);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    sense = 13'h1AE0; // Supplies up, input in range
    @(negedge mclk);
    chk_mode("reset mode", CPP_START);
    chk_word("reset paths", 0, switches);
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    i_cpp_host_model.rd(`CPP_OFS_CTRL, rdat);
    chk_word("control default", 0, rdat);
    i_cpp_host_model.wr(`CPP_OFS_CTRL, 32'h2);
    wait_mode(CPP_SYSTEM_ONLY, DGL + 30);
    chk_mode("first mode", CPP_SYSTEM_ONLY);
    chk_word("system-only paths", 32'h68, paths());
    chk_word("valid input", 1, inputValid);
    i_cpp_host_model.wr(`CPP_OFS_CTRL, 32'h0);
    wait_mode(CPP_CHARGING, 6);
    chk_mode("inhibit cleared", CPP_CHARGING);
    chk_word("charging paths", 32'h78, paths());
    end_test("startup");

    @(posedge mclk);
    sense.dieHot <= 1'b1;
    repeat (5) @(negedge mclk);
    chk_word("thermal reduce", 1, switches.chargeReduce);
    @(posedge mclk);
    sense[2:0] <= 3'b011; // Overload
    repeat (5) @(negedge mclk);
    chk_word("overload", 3, {switches.chargeReduce, switches.supplementEn});
    @(posedge mclk);
    sense[2:0] <= 3'b000;
    end_test("regulation");

    @(posedge mclk);
    sense[10:9] <= 2'b10; // Over-voltage
    count_alert;
    chk_word("ovp alert", ALRT, alen);
    chk_mode("ovp mode", CPP_BATTERY_DISCHARGE);
    chk_word("ovp paths", 32'h10, paths());
    chk_word("ovp valid", 0, inputValid);
    i_cpp_host_model.rd(`CPP_OFS_FAULT, rdat);
    chk_word("ovp flags", 32'h20, rdat);
    i_cpp_host_model.rd(`CPP_OFS_FAULT, rdat);
    chk_word("flags read-clear", 0, rdat);
    @(posedge mclk);
    sense[10:9] <= 2'b01;
    repeat (DGL / 2) @(posedge mclk);
    sense.vinBelowOvpExit <= 1'b0;
    @(posedge mclk);
    sense.vinBelowOvpExit <= 1'b1;
    recover("ovp recovery");
    end_test("overvoltage");

    @(posedge mclk);
    sense[8:4] <= 5'b10011; // Below lockout
    count_alert;
    chk_word("uvlo alert", ALRT, alen);
    chk_mode("input removed", CPP_BATTERY_DISCHARGE);
    chk_word("uvlo paths", 32'h10, paths());
    chk_word("uvlo valid", 0, inputValid);
    i_cpp_host_model.rd(`CPP_OFS_FAULT, rdat);
    chk_word("uvlo flags", 32'h20, rdat);
    @(posedge mclk);
    sense[8:4] <= 5'b01110;
    recover("uvlo recovery");
    end_test("undervoltage");

    i_cpp_host_model.wr(`CPP_OFS_CTRL, 32'h4);
    wait_mode(CPP_STORAGE, 6);
    chk_mode("battery off", CPP_STORAGE);
    chk_word("storage paths", 32'h04, paths());
    i_cpp_host_model.wr(`CPP_OFS_CTRL, 32'h0);
    wait_mode(CPP_CHARGING, 12);
    chk_mode("storage left", CPP_CHARGING);
    i_cpp_host_model.wr(`CPP_OFS_STATE, 32'hFFFFFFFF);
    i_cpp_host_model.wr(`CPP_OFS_CTRL, 32'h2);
    i_cpp_host_model.rd(`CPP_OFS_CTRL, rdat);
    chk_word("control readback", 32'h2, rdat);
    i_cpp_host_model.rd(8'h0C, rdat);
    chk_word("unmapped read", 0, rdat);
    wait_mode(CPP_SYSTEM_ONLY, 6);
    chk_word("inhibited paths", 32'h68, paths());
    i_cpp_host_model.rd(`CPP_OFS_STATE, rdat);
    chk_word("state word", 32'h1D0C, rdat);
    i_cpp_host_model.wr(`CPP_OFS_CTRL, 32'h3);
    repeat (3) @(negedge mclk);
    chk_word("highz paths", 32'h10, paths());
    end_test("storage and registers");
    close_out;
  end
endmodule // testbench
